// file: logic/login_w1_host.sv
`timescale 1ns/100ps
module login_w1_host #(
    parameter int XID_W = 4
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    output logic                      tx_w1_valid,
    output login_w1_pkg::frame_e      tx_w1_type,
    output logic      [31:0]          tx_w1,
    input  wire logic                 rx_w1_valid,
    input  login_w1_pkg::frame_e      rx_w1_type,
    input  wire logic [31:0]          rx_w1,
    input  wire logic                 seq_valid,
    output logic                      seq_ready,
    input  wire logic [XID_W-1:0]     seq_xid,
    input  login_w1_pkg::seq_req_s    seq_req,
    output logic                      seq_ans_valid,
    output login_w1_pkg::seq_ans_s    seq_ans
);

    // ****************************************
    // elaboration checks
    // ****************************************
    generate
        if (XID_W < 1 || XID_W > 12) begin : g_bad_xid
            $error("XID_W must lie between 1 and 12");
        end
    endgenerate

    localparam int MEM_DW = $bits(login_w1_pkg::seq_ans_s);

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_DONE = 2'b10
    } seq_state_e;

    typedef struct packed {
        login_w1_pkg::cfg_s     cfg;
        logic [31:0]            txw;
        logic                   txv;
        login_w1_pkg::frame_e   txt;
        logic [31:0]            rxw;
        login_w1_pkg::frame_e   rxt;
        logic [7:0]             rxcnt;
        logic                   req31;
        logic                   req26;
        logic                   ns_session;
        logic [31:0]            rdata;
        seq_state_e             sst;
        logic [XID_W-1:0]       xid;
        login_w1_pkg::seq_req_s req;
        logic                   ansv;
        login_w1_pkg::seq_ans_s ans;
    } host_state_s;

    host_state_s st_r;
    host_state_s st_nxt;

    login_w1_pkg::flags_s   dec_flags;
    login_w1_pkg::flags_s   dec_applic;
    logic [MEM_DW-1:0]      mem_rdata;
    logic                   mem_rd;
    logic                   mem_wr;
    logic [MEM_DW-1:0]      mem_wdata;

    // ****************************************
    // word 1 builder
    // ****************************************
    function automatic logic [31:0] build_w1(
        input login_w1_pkg::frame_e ft,
        input login_w1_pkg::cfg_s   c,
        input logic                 r31,
        input logic                 r26
    );
        logic [31:0] w;
        logic        facc;
        logic        freq;
        w    = 32'h0000_0000;
        facc = (ft == login_w1_pkg::FT_FLOGI_ACC);
        freq = (ft == login_w1_pkg::FT_FLOGI);
        w[login_w1_pkg::W1_B31] = freq && c.mnpid_support;
        if (facc) begin
            w[login_w1_pkg::W1_B29] = r31 && c.mnpid_assign_cap;
        end else begin
            w[login_w1_pkg::W1_B29] = c.vvl_valid;
        end
        // role bit only in fabric reply
        w[login_w1_pkg::W1_B28] = facc && c.is_fabric;
        if (facc) begin
            w[login_w1_pkg::W1_B27] = r26 && c.is_fabric;
        end else begin
            w[login_w1_pkg::W1_B27] = c.alt_credit;
        end
        w[login_w1_pkg::W1_B26] = freq ? c.ns_begin : c.edtov_ns;
        w[login_w1_pkg::W1_B24] = facc ? (c.broadcast && c.is_fabric) : c.app_hdr;
        w[login_w1_pkg::W1_B23] = c.prio_tag && c.prio_class;
        w[login_w1_pkg::W1_B22] = c.qbc_req && c.rpbc_support
                                  && (c.els_size_diff || c.no_multiframe);
        w[login_w1_pkg::W1_B20] = !freq && c.clk_sync;
        w[login_w1_pkg::W1_B19] = c.rttov_short;
        w[login_w1_pkg::W1_B18] = c.dhd;
        w[login_w1_pkg::W1_B17] = (facc || freq) ? c.vendor17 : c.seq_cont;
        return w;
    endfunction

    // ****************************************
    // receive decoder
    // ****************************************
    // per-type decode
    w1_decode u_dec (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .in_valid (rx_w1_valid),
        .ftype    (rx_w1_type),
        .w1       (rx_w1),
        .flags    (dec_flags),
        .applic   (dec_applic)
    );

    // ****************************************
    // per-exchange counter memory
    // ****************************************
    seq_mem #(
        .AW (XID_W),
        .DW (MEM_DW)
    ) u_mem (
        .sys_clk (sys_clk),
        .reset   (reset),
        .rd_en   (mem_rd),
        .raddr   (seq_xid),
        .rdata   (mem_rdata),
        .wr_en   (mem_wr),
        .waddr   (st_r.xid),
        .wdata   (mem_wdata)
    );

    // one exchange update in flight: avoids a read-modify-write race
    assign seq_ready = (st_r.sst == S_IDLE);
    assign mem_rd    = seq_ready && seq_valid;
    assign mem_wr    = (st_r.sst == S_READ);
    assign mem_wdata = st_nxt.ans;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        login_w1_pkg::seq_ans_s old;
        login_w1_pkg::seq_ans_s nw;
        logic [31:0]            rmux;
        old    = login_w1_pkg::seq_ans_s'(mem_rdata);
        nw     = old;
        rmux   = 32'h0000_0000;
        st_nxt = st_r;
        st_nxt.txv  = 1'b0;
        st_nxt.ansv = 1'b0;

        if (reg_wr && reg_addr == login_w1_pkg::OFF_CTRL) begin
            st_nxt.cfg = login_w1_pkg::cfg_s'(reg_wdata[$bits(login_w1_pkg::cfg_s)-1:0]);
        end
        if (reg_wr && reg_addr == login_w1_pkg::OFF_CMD) begin
            st_nxt.txt = login_w1_pkg::frame_e'(reg_wdata[1:0]);
            st_nxt.txw = build_w1(login_w1_pkg::frame_e'(reg_wdata[1:0]), st_r.cfg,
                                  st_r.req31, st_r.req26);
            st_nxt.txv = 1'b1;
        end

        if (rx_w1_valid) begin
            st_nxt.rxw   = rx_w1;
            st_nxt.rxt   = rx_w1_type;
            st_nxt.rxcnt = st_r.rxcnt + 8'h01;
            if (rx_w1_type == login_w1_pkg::FT_FLOGI) begin
                st_nxt.req31 = rx_w1[login_w1_pkg::W1_B31];
                st_nxt.req26 = rx_w1[login_w1_pkg::W1_B26];
                st_nxt.ns_session = rx_w1[login_w1_pkg::W1_B26] && st_r.cfg.is_fabric;
            end
        end

        case (st_r.sst)
            S_IDLE: begin
                if (seq_valid) begin
                    st_nxt.xid = seq_xid;
                    st_nxt.req = seq_req;
                    st_nxt.sst = S_READ;
                end
            end
            S_READ: begin
                if (st_r.req.kind == login_w1_pkg::SK_RX) begin
                    if (st_r.req.first) begin
                        nw.prio = st_r.req.prio;
                        nw.cnt  = 16'h0000;
                    end
                end else begin
                    if (st_r.req.first && st_r.req.orig) begin
                        nw.prio = st_r.req.prio;
                    end
                    if (st_r.req.first || (st_r.req.new_seq && !st_r.cfg.seq_cont)) begin
                        nw.cnt = 16'h0000;
                    end else begin
                        nw.cnt = old.cnt + 16'h0001;
                    end
                end
                st_nxt.ans  = nw;
                st_nxt.ansv = 1'b1;
                st_nxt.sst  = S_DONE;
            end
            S_DONE: begin
                st_nxt.sst = S_IDLE;
            end
            default: begin
                st_nxt.sst = S_IDLE;
            end
        endcase

        case (reg_addr)
            login_w1_pkg::OFF_CTRL: rmux = 32'(st_r.cfg);
            login_w1_pkg::OFF_STAT: begin
                rmux[login_w1_pkg::STAT_TYPE_LSB +: 2] = st_r.rxt;
                rmux[login_w1_pkg::STAT_NS_BIT]        = st_r.ns_session;
                rmux[login_w1_pkg::STAT_CONT_BIT]      = st_r.cfg.seq_cont;
                rmux[login_w1_pkg::STAT_CNT_LSB +: 8]  = st_r.rxcnt;
            end
            login_w1_pkg::OFF_TXW:  rmux = st_r.txw;
            login_w1_pkg::OFF_RXW:  rmux = st_r.rxw;
            login_w1_pkg::OFF_RXF:  rmux = 32'(dec_flags);
            login_w1_pkg::OFF_RXA:  rmux = 32'(dec_applic);
            login_w1_pkg::OFF_SEQ:  rmux = 32'(st_r.ans);
            default:                rmux = 32'h0000_0000;
        endcase
        // read data valid only in the cycle after the strobe
        st_nxt.rdata = reg_rd ? rmux : 32'h0000_0000;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r     <= '0;
            st_r.cfg <= login_w1_pkg::cfg_s'(login_w1_pkg::CTRL_RST[$bits(login_w1_pkg::cfg_s)-1:0]);
            st_r.sst <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata     = st_r.rdata;
    assign tx_w1_valid   = st_r.txv;
    assign tx_w1_type    = st_r.txt;
    assign tx_w1         = st_r.txw;
    assign seq_ans_valid = st_r.ansv;
    assign seq_ans       = st_r.ans;

endmodule

// file: inc/login_w1_pkg.sv
package login_w1_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam logic [7:0]  OFF_CTRL  = 8'h00;
    localparam logic [7:0]  OFF_CMD   = 8'h04;
    localparam logic [7:0]  OFF_STAT  = 8'h08;
    localparam logic [7:0]  OFF_TXW   = 8'h0C;
    localparam logic [7:0]  OFF_RXW   = 8'h10;
    localparam logic [7:0]  OFF_RXF   = 8'h14;
    localparam logic [7:0]  OFF_RXA   = 8'h18;
    localparam logic [7:0]  OFF_SEQ   = 8'h1C;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

    // ****************************************
    // word 1 bit positions
    // ****************************************
    localparam int W1_B31 = 31;
    localparam int W1_B29 = 29;
    localparam int W1_B28 = 28;
    localparam int W1_B27 = 27;
    localparam int W1_B26 = 26;
    localparam int W1_B24 = 24;
    localparam int W1_B23 = 23;
    localparam int W1_B22 = 22;
    localparam int W1_B20 = 20;
    localparam int W1_B19 = 19;
    localparam int W1_B18 = 18;
    localparam int W1_B17 = 17;

    // ****************************************
    // field layouts
    // ****************************************
    localparam int STAT_TYPE_LSB = 0;
    localparam int STAT_NS_BIT   = 2;
    localparam int STAT_CONT_BIT = 3;
    localparam int STAT_CNT_LSB  = 8;
    localparam int PRIO_W        = 8;
    localparam int SEQCNT_W      = 16;

    typedef enum logic [1:0] {
        FT_PLOGI     = 2'b00,
        FT_PLOGI_ACC = 2'b01,
        FT_FLOGI     = 2'b10,
        FT_FLOGI_ACC = 2'b11
    } frame_e;

    typedef enum logic {
        SK_TX = 1'b0,
        SK_RX = 1'b1
    } seq_kind_e;

    // local features, low bits of the control register
    typedef struct packed {
        logic vendor17;
        logic seq_cont;
        logic dhd;
        logic rttov_short;
        logic clk_sync;
        logic no_multiframe;
        logic els_size_diff;
        logic rpbc_support;
        logic qbc_req;
        logic prio_class;
        logic prio_tag;
        logic broadcast;
        logic app_hdr;
        logic edtov_ns;
        logic ns_begin;
        logic alt_credit;
        logic is_fabric;
        logic mnpid_assign_cap;
        logic mnpid_support;
        logic vvl_valid;
    } cfg_s;

    typedef struct packed {
        logic vendor17;
        logic seq_cont;
        logic dhd;
        logic rttov_short;
        logic clk_sync;
        logic qbc;
        logic prio_tag;
        logic broadcast;
        logic app_hdr;
        logic edtov_ns;
        logic ns_begin;
        logic ns_started;
        logic alt_credit;
        logic port_role;
        logic mnpid_support;
        logic mnpid_assign;
        logic vvl_valid;
    } flags_s;

    typedef struct packed {
        seq_kind_e         kind;
        logic              first;
        logic              orig;
        logic              new_seq;
        logic [PRIO_W-1:0] prio;
    } seq_req_s;

    typedef struct packed {
        logic [PRIO_W-1:0]   prio;
        logic [SEQCNT_W-1:0] cnt;
    } seq_ans_s;

endpackage

// file: logic/seq_mem.sv
`timescale 1ns/100ps
module seq_mem #(
    parameter int AW = 4,
    parameter int DW = 24
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata
);

    // ****************************************
    // storage
    // ****************************************
    // array has no reset: every exchange starts with a first-frame write
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = rd_en ? mem[raddr] : rdata_r;
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule

// file: logic/w1_decode.sv
`timescale 1ns/100ps
module w1_decode (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  in_valid,
    input  login_w1_pkg::frame_e       ftype,
    input  wire logic [31:0]           w1,
    output login_w1_pkg::flags_s       flags,
    output login_w1_pkg::flags_s       applic
);

    typedef struct packed {
        login_w1_pkg::flags_s f;
        login_w1_pkg::flags_s a;
    } dec_state_s;

    dec_state_s st_r;
    dec_state_s st_nxt;

    // ****************************************
    // applicability per frame type
    // ****************************************
    function automatic login_w1_pkg::flags_s applic_of(input login_w1_pkg::frame_e ft);
        login_w1_pkg::flags_s a;
        logic                 facc;
        logic                 freq;
        facc = (ft == login_w1_pkg::FT_FLOGI_ACC);
        freq = (ft == login_w1_pkg::FT_FLOGI);
        // vendor version not in fabric reply
        a.vvl_valid     = !facc;
        a.mnpid_assign  = facc;
        a.mnpid_support = freq;
        a.port_role     = 1'b1;
        a.alt_credit    = !facc;
        a.ns_started    = facc;
        // session begin only in fabric login
        a.ns_begin      = freq;
        a.edtov_ns      = !freq;
        a.app_hdr       = !facc;
        a.broadcast     = facc;
        a.prio_tag      = 1'b1;
        a.qbc           = 1'b1;
        // clock sync not in fabric request
        a.clk_sync      = !freq;
        a.rttov_short   = 1'b1;
        a.dhd           = 1'b1;
        // bit 17 vendor specific in fabric frames
        a.seq_cont      = !(facc || freq);
        a.vendor17      = facc || freq;
        return a;
    endfunction

    always_comb begin
        login_w1_pkg::flags_s raw;
        login_w1_pkg::flags_s ap;
        raw = '0;
        ap  = applic_of(ftype);
        st_nxt = st_r;
        raw.vvl_valid     = w1[login_w1_pkg::W1_B29];
        raw.mnpid_assign  = w1[login_w1_pkg::W1_B29];
        raw.mnpid_support = w1[login_w1_pkg::W1_B31];
        raw.port_role     = w1[login_w1_pkg::W1_B28];
        raw.alt_credit    = w1[login_w1_pkg::W1_B27];
        raw.ns_started    = w1[login_w1_pkg::W1_B27];
        raw.ns_begin      = w1[login_w1_pkg::W1_B26];
        raw.edtov_ns      = w1[login_w1_pkg::W1_B26];
        raw.app_hdr       = w1[login_w1_pkg::W1_B24];
        raw.broadcast     = w1[login_w1_pkg::W1_B24];
        raw.prio_tag      = w1[login_w1_pkg::W1_B23];
        raw.qbc           = w1[login_w1_pkg::W1_B22];
        raw.clk_sync      = w1[login_w1_pkg::W1_B20];
        raw.rttov_short   = w1[login_w1_pkg::W1_B19];
        raw.dhd           = w1[login_w1_pkg::W1_B18];
        raw.seq_cont      = w1[login_w1_pkg::W1_B17];
        raw.vendor17      = w1[login_w1_pkg::W1_B17];
        if (in_valid) begin
            // not-applicable flags read as zero
            st_nxt.f = raw & ap;
            st_nxt.a = ap;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags  = st_r.f;
    assign applic = st_r.a;

endmodule

// file: tb/login_w1_host_sva.sv
`timescale 1ns/100ps
module login_w1_host_sva (
    input wire logic            sys_clk,
    input wire logic            reset,
    input wire logic [7:0]      reg_addr,
    input wire logic [31:0]     reg_wdata,
    input wire logic            reg_wr,
    input wire logic            tx_w1_valid,
    input login_w1_pkg::frame_e tx_w1_type,
    input wire logic [31:0]     tx_w1,
    input wire logic            rx_w1_valid,
    input login_w1_pkg::frame_e rx_w1_type,
    input wire logic [31:0]     rx_w1,
    input wire logic            seq_valid,
    input wire logic            seq_ready,
    input wire logic            seq_ans_valid
);
    // ****************************************
    // shadow of config and last fabric login
    // ****************************************
    login_w1_pkg::cfg_s cfg_r;
    logic               req31_r;
    logic               req26_r;
    logic               acc_w;
    logic               plg_w;
    assign acc_w = tx_w1_valid && tx_w1_type == login_w1_pkg::FT_FLOGI_ACC;
    assign plg_w = tx_w1_valid && !tx_w1_type[1];
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_r   <= '0;
            req31_r <= 1'b0;
            req26_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == login_w1_pkg::OFF_CTRL) begin
                cfg_r <= reg_wdata[19:0];
            end
            if (rx_w1_valid && rx_w1_type == login_w1_pkg::FT_FLOGI) begin
                req31_r <= rx_w1[31];
                req26_r <= rx_w1[26];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_NODE_ROLE: assert property (tx_w1_valid && !acc_w |-> !tx_w1[28])
        else $error("role bit set by node port");
    AST_FABRIC_ROLE: assert property (acc_w |-> tx_w1[28] == cfg_r.is_fabric)
        else $error("role bit wrong in fabric reply");
    AST_MNPID_GATE: assert property (acc_w && tx_w1[29] |-> req31_r && cfg_r.mnpid_assign_cap)
        else $error("id assignment bit without cause");
    AST_NS_GATE: assert property (acc_w && tx_w1[27] |-> req26_r)
        else $error("session bit without request");
    AST_PRIO_GATE: assert property (tx_w1_valid && tx_w1[23] |-> cfg_r.prio_class)
        else $error("priority tag bit without class bit");
    AST_QBC_GATE: assert property (tx_w1_valid && tx_w1[22] |-> cfg_r.rpbc_support
        && (cfg_r.els_size_diff || cfg_r.no_multiframe)) else $error("buffer bit without cause");
    AST_SEQ_BIT: assert property (plg_w |-> tx_w1[17] == cfg_r.seq_cont)
        else $error("count mode bit wrong");
    AST_ANS_TIME: assert property (seq_valid && seq_ready |=> !seq_ready
        ##1 (seq_ans_valid && !seq_ready) ##1 seq_ready) else $error("count answer late");
    cover property (acc_w && tx_w1[29]);
    cover property (seq_ans_valid);
    cover property (rx_w1_valid && rx_w1_type == login_w1_pkg::FT_FLOGI_ACC);
endmodule

bind login_w1_host login_w1_host_sva chk_u (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .tx_w1_valid(tx_w1_valid), .tx_w1_type(tx_w1_type), .tx_w1(tx_w1),
    .rx_w1_valid(rx_w1_valid), .rx_w1_type(rx_w1_type), .rx_w1(rx_w1),
    .seq_valid(seq_valid), .seq_ready(seq_ready), .seq_ans_valid(seq_ans_valid)
);

// file: tb/remote_port_model.sv
`timescale 1ns/100ps
module remote_port_model (
    input  wire logic            sys_clk,
    input  wire logic            reset,
    input  wire logic            send,
    input  login_w1_pkg::frame_e send_type,
    input  wire logic [31:0]     send_w1,
    input  wire logic [3:0]      lag,
    output logic                 rx_w1_valid,
    output login_w1_pkg::frame_e rx_w1_type,
    output logic [31:0]          rx_w1
);
    // ****************************************
    // frame delivery, prompt or late
    // ****************************************
    logic [3:0] wait_r;
    logic       busy_r;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_r      <= 4'h0;
            busy_r      <= 1'b0;
            rx_w1_valid <= 1'b0;
            rx_w1_type  <= login_w1_pkg::FT_PLOGI;
            rx_w1       <= 32'h0;
        end else begin
            rx_w1_valid <= 1'b0;
            // idle word toggles so stale data never passes
            rx_w1       <= ~rx_w1;
            if (send) begin
                busy_r <= 1'b1;
                wait_r <= lag;
            end else if (busy_r && wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (busy_r) begin
                busy_r      <= 1'b0;
                rx_w1_valid <= 1'b1;
                rx_w1_type  <= send_type;
                // role bit only in fabric reply
                rx_w1       <= send_type == login_w1_pkg::FT_FLOGI_ACC ? send_w1 : send_w1 & 32'hEFFFFFFF;
            end
        end
    end
endmodule

// file: tb/test_login_common_features_codec.sv
`timescale 1ns/100ps
module test_login_common_features_codec;
    logic                   sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                   seq_valid = 1'b0, send = 1'b0;
    logic                   tx_w1_valid, rx_w1_valid, seq_ready, seq_ans_valid;
    logic [7:0]             reg_addr = 8'h00, p;
    logic [31:0]            reg_wdata = 32'h0, send_w1 = 32'h0, reg_rdata, tx_w1, rx_w1, d;
    logic [3:0]             seq_xid = 4'h0, lag = 4'h0, x;
    logic [19:0]            c;
    login_w1_pkg::frame_e   tx_w1_type, rx_w1_type, send_type = login_w1_pkg::FT_PLOGI;
    login_w1_pkg::seq_req_s seq_req = '0;
    login_w1_pkg::seq_ans_s seq_ans;
    int                     n_fail = 0, samples_checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    login_w1_host dut_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_w1_valid(tx_w1_valid), .tx_w1_type(tx_w1_type), .tx_w1(tx_w1),
        .rx_w1_valid(rx_w1_valid), .rx_w1_type(rx_w1_type), .rx_w1(rx_w1),
        .seq_valid(seq_valid), .seq_ready(seq_ready), .seq_xid(seq_xid), .seq_req(seq_req),
        .seq_ans_valid(seq_ans_valid), .seq_ans(seq_ans));
    remote_port_model peer_u (.sys_clk(sys_clk), .reset(reset), .send(send),
        .send_type(send_type), .send_w1(send_w1), .lag(lag), .rx_w1_valid(rx_w1_valid),
        .rx_w1_type(rx_w1_type), .rx_w1(rx_w1));

    // ****************************************
    // bus tasks and expectations
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic snd(input login_w1_pkg::frame_e ft, input logic [31:0] w);
        @(posedge sys_clk);
        send <= 1'b1;
        send_type <= ft;
        send_w1 <= w;
        lag <= 4'($urandom);
        @(posedge sys_clk);
        send <= 1'b0;
        for (int i = 0; i < 40 && rx_w1_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    task automatic sq(input login_w1_pkg::seq_kind_e k, input logic [2:0] fon,
                      input logic [7:0] pr, input logic [3:0] xi, input logic [31:0] e);
        @(posedge sys_clk);
        seq_valid <= 1'b1;
        seq_xid <= xi;
        seq_req <= '{k, fon[2], fon[1], fon[0], pr};
        @(posedge sys_clk);
        seq_valid <= 1'b0;
        for (int i = 0; i < 8 && seq_ans_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk({8'h00, seq_ans}, e);
    endtask
    function automatic logic [31:0] exp_tx(input logic [1:0] t, input logic [19:0] cf);
        return {3'h0, t == 2'd3 && cf[3], 10'h0, t < 2'd2 && cf[18], 14'h0, t, 1'b1};
    endfunction
    function automatic logic [31:0] exp_fl(input logic [1:0] t);
        return {16'h0, t < 2'd2, 5'h0, t == 2'd3, t != 2'd3, 8'h0};
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        test_done();
    end

    initial begin
        void'($urandom(32'h6cb3));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd(login_w1_pkg::OFF_CTRL, d);
        chk(d, login_w1_pkg::CTRL_RST);
        rd(8'h40, d);
        chk(d, 32'h0);
        wr(login_w1_pkg::OFF_CTRL, 32'hFFFFFFFF);
        rd(login_w1_pkg::OFF_CTRL, d);
        chk(d, 32'h000FFFFF);
        for (int i = 0; i < 12; i++) begin
            c = 20'($urandom);
            wr(login_w1_pkg::OFF_CTRL, {12'h0, c});
            snd(login_w1_pkg::FT_FLOGI, $urandom);
            for (int t = 0; t < 4; t++) begin
                wr(login_w1_pkg::OFF_CMD, 32'(t));
                #1 d = (tx_w1 & (t < 2 ? 32'h1002FFF8 : 32'h1000FFF8)) | {tx_w1_type, tx_w1_valid};
                chk(d, exp_tx(2'(t), c));
            end
        end
        for (int t = 0; t < 4; t++) begin
            snd(login_w1_pkg::frame_e'(t), 32'hFFFF0000);
            rd(login_w1_pkg::OFF_RXF, d);
            chk(d & 32'h8300, exp_fl(2'(t)));
            rd(login_w1_pkg::OFF_RXA, d);
            chk(d & 32'h8300, exp_fl(2'(t)));
        end
        rd(login_w1_pkg::OFF_STAT, d);
        chk(d, {16'h0, 8'h10, 4'h0, c[18], c[3], 2'b11});
        wr(login_w1_pkg::OFF_CTRL, 32'h00040000);
        x = 4'($urandom);
        p = 8'($urandom);
        sq(login_w1_pkg::SK_TX, 3'b110, p, x, {8'h00, p, 16'h0000});
        sq(login_w1_pkg::SK_TX, 3'b001, ~p, x, {8'h00, p, 16'h0001});
        sq(login_w1_pkg::SK_RX, 3'b000, 8'h00, x, {8'h00, p, 16'h0001});
        sq(login_w1_pkg::SK_TX, 3'b000, 8'h00, x, {8'h00, p, 16'h0002});
        sq(login_w1_pkg::SK_RX, 3'b100, ~p, x ^ 4'h1, {8'h00, ~p, 16'h0000});
        sq(login_w1_pkg::SK_TX, 3'b100, p, x ^ 4'h1, {8'h00, ~p, 16'h0000});
        wr(login_w1_pkg::OFF_CTRL, 32'h0);
        sq(login_w1_pkg::SK_TX, 3'b001, p, x, {8'h00, p, 16'h0000});
        rd(login_w1_pkg::OFF_SEQ, d);
        chk(d, {8'h00, p, 16'h0000});
        test_done();
    end
endmodule
